// >>> core/fps_pkg.sv
// constants for the page program and erase flash controller
`default_nettype none
package fps_pkg;
  // software register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // operation codes written to REG_CMD
  localparam int OP_W = 3;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_RD_ARRAY = 3'h1;
  localparam logic [2:0] OP_RD_STATUS = 3'h2;
  localparam logic [2:0] OP_CLR_STATUS = 3'h3;
  localparam logic [2:0] OP_PROGRAM = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  // REG_STATUS field positions
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_LOADED = 2;
  localparam int ST_FLASH_LSB = 8;
  // flash status byte bits
  localparam int FS_READY = 7;
  localparam int FS_ERASE_FAIL = 5;
  localparam int FS_PROG_FAIL = 4;
  localparam logic [7:0] FS_RESET = 8'h80;
  // flash bus geometry
  localparam int ADDR_W = 20;
  localparam int DQ_W = 16;
  localparam int WIDX_W = 6;
  localparam int PAGE_WORDS = 64;
  // command cycle addresses and data
  localparam logic [14:0] UNLOCK_A1 = 15'h5555;
  localparam logic [14:0] UNLOCK_A2 = 15'h2AAA;
  localparam logic [7:0] UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_RD_ARRAY = 8'hF0;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_ERASE_CHIP = 8'h10;
  // timing, clock 40 MHz
  localparam int T_CLK_NS = 25;
  localparam int T_WP_NS = 60;
  localparam int T_WPH_NS = 50;
  localparam int T_ACC_NS = 120;
  localparam int T_VPS_NS = 2000;
  localparam int T_VPH_NS = 2000;
  localparam int T_LOAD_END_NS = 100000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CY_WP = CNT_W'((T_WP_NS + T_CLK_NS - 1)
    / T_CLK_NS);
  localparam logic [CNT_W-1:0] CY_WPH = CNT_W'((T_WPH_NS + T_CLK_NS - 1)
    / T_CLK_NS);
  localparam logic [CNT_W-1:0] CY_ACC = CNT_W'((T_ACC_NS + T_CLK_NS - 1)
    / T_CLK_NS + 1);
  localparam logic [CNT_W-1:0] CY_VPS = CNT_W'((T_VPS_NS + T_CLK_NS - 1)
    / T_CLK_NS);
  localparam logic [CNT_W-1:0] CY_VPH = CNT_W'((T_VPH_NS + T_CLK_NS - 1)
    / T_CLK_NS);
  // one cycle beyond the device's load window so programming has begun
  localparam logic [CNT_W-1:0] CY_LOAD_END = CNT_W'((T_LOAD_END_NS
    + T_CLK_NS - 1) / T_CLK_NS + 1);
endpackage
`default_nettype wire

// >>> core/fps_host.sv
// host controller driving a parallel flash through program/erase commands
//
// What this block does
// - program begins with two unlock writes then the program code
// - each word load follows the previous within 100 us
// - upper address bits pick the page, held at every word-load select fall
// - chip erase uses six writes: unlock, setup, unlock, erase code
// - status frozen at select or gate fall; toggle for every poll
// - with a fail flag set, program and erase are refused
// - write needs select low, gate high and the high program level
// - unlock addresses 5555 and 2AAA on the low fifteen bits
`default_nettype none
module fps_host (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // flash pins
  output logic [fps_pkg::ADDR_W-1:0] flash_addr,
  output logic [fps_pkg::DQ_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [fps_pkg::DQ_W-1:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_word_mode,
  output logic flash_program_high_level
);
  import fps_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_VPP, S_WSET, S_WLOW, S_WHIGH, S_SCAN, S_VPPDN, S_LOADEND,
    S_RLOW, S_RHIGH
  } fps_state_t;

  // bus phase state
  logic wr_pend, next_wr_pend, rd_pend, next_rd_pend;
  logic [7:0] ph_addr, next_ph_addr;
  logic next_hreadyout;
  logic [31:0] next_hrdata;

  // sequencer state
  fps_state_t state, next_state;
  logic [OP_W-1:0] op, next_op;
  logic [2:0] step, next_step;
  logic [WIDX_W-1:0] widx, next_widx;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [7:0] fstat, next_fstat;
  logic [DQ_W-1:0] rdata, next_rdata;
  logic [PAGE_WORDS-1:0] mask, next_mask;
  logic refused, next_refused;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [DQ_W-1:0] next_flash_dq_o;
  logic next_flash_dq_oe, next_flash_ce_n, next_flash_oe_n, next_vpp;

  // page buffer
  logic [DQ_W-1:0] page_buf [PAGE_WORDS];
  logic buf_we;

  logic busy, bus_wr, is_status_op;
  logic [7:0] cyc_data;
  logic [14:0] cyc_addr;

  assign busy = (state != S_IDLE);
  assign bus_wr = wr_pend & hready;
  assign is_status_op = (op != OP_READ) && (op != OP_RD_ARRAY);

  // unlock and command cycles by step
  always_comb begin
    cyc_addr = UNLOCK_A1;
    cyc_data = UNLOCK_D1;
    unique case (step)
      3'd1, 3'd4: begin
        cyc_addr = UNLOCK_A2;
        cyc_data = UNLOCK_D2;
      end
      3'd2: begin
        unique case (op)
          OP_RD_STATUS: cyc_data = CMD_RD_STATUS;
          OP_CLR_STATUS: cyc_data = CMD_CLR_STATUS;
          OP_PROGRAM: cyc_data = CMD_PROGRAM;
          OP_ERASE: cyc_data = CMD_ERASE_SETUP;
          default: cyc_data = CMD_RD_ARRAY;
        endcase
      end
      3'd5: cyc_data = CMD_ERASE_CHIP;
      default: cyc_data = UNLOCK_D1;
    endcase
  end

  // ahb-lite slave phases; reads take one wait state
  always_comb begin
    next_wr_pend = wr_pend;
    next_rd_pend = 1'b0;
    next_ph_addr = ph_addr;
    next_hreadyout = 1'b1;
    next_hrdata = hrdata;
    if (hready) begin
      next_wr_pend = 1'b0;
      if (hsel && htrans[1]) begin
        next_ph_addr = haddr[7:0];
        next_wr_pend = hwrite;
        next_rd_pend = !hwrite;
        next_hreadyout = hwrite;
      end
    end
    if (rd_pend) begin
      unique case (ph_addr)
        REG_CMD: next_hrdata = {29'h0, op};
        REG_ADDR: next_hrdata = {12'h0, addr};
        REG_DATA: next_hrdata = {16'h0, page_buf[addr[WIDX_W-1:0]]};
        REG_STATUS: next_hrdata = {16'h0, fstat, 5'h0, |mask, refused,
          busy};
        REG_RDATA: next_hrdata = {16'h0, rdata};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= 8'h0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else if (clk_en) begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      ph_addr <= next_ph_addr;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
    end
  end

  // page buffer writes from software, ignored while busy
  assign buf_we = bus_wr && (ph_addr == REG_DATA) && !busy;

  always_ff @(posedge hclk) begin
    if (clk_en && buf_we) begin
      page_buf[addr[WIDX_W-1:0]] <= hwdata[DQ_W-1:0];
    end
  end

  // sequencer
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_widx = widx;
    next_cnt = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
    next_addr = addr;
    next_fstat = fstat;
    next_rdata = rdata;
    next_mask = mask;
    next_refused = refused;
    next_flash_addr = flash_addr;
    next_flash_dq_o = flash_dq_o;
    if (!busy && bus_wr && (ph_addr == REG_ADDR)) begin
      next_addr = hwdata[ADDR_W-1:0];
    end
    if (buf_we) begin
      next_mask[addr[WIDX_W-1:0]] = 1'b1;
    end
    unique case (state)
      S_IDLE: begin
        if (bus_wr && (ph_addr == REG_CMD)) begin
          next_op = hwdata[OP_W-1:0];
          next_step = 3'd0;
          next_widx = '0;
          next_refused = 1'b0;
          if ((hwdata[OP_W-1:0] == OP_PROGRAM
               || hwdata[OP_W-1:0] == OP_ERASE)
              && (fstat[FS_ERASE_FAIL] || fstat[FS_PROG_FAIL])) begin
            next_refused = 1'b1;
          end else if (hwdata[OP_W-1:0] == OP_READ) begin
            next_flash_addr = addr;
            next_cnt = CY_ACC;
            next_state = S_RLOW;
          end else if (hwdata[OP_W-1:0] <= OP_ERASE) begin
            next_cnt = CY_VPS;
            next_state = S_VPP;
          end
        end
      end
      S_VPP: begin
        if (cnt == '0) begin
          next_flash_addr = {5'h0, cyc_addr};
          next_flash_dq_o = {8'h0, cyc_data};
          next_state = S_WSET;
        end
      end
      S_WSET: begin
        next_cnt = CY_WP;
        next_state = S_WLOW;
      end
      S_WLOW: begin
        if (cnt == '0) begin
          next_cnt = CY_WPH;
          next_state = S_WHIGH;
        end
      end
      S_WHIGH: begin
        if (cnt == '0) begin
          if (op == OP_PROGRAM && step >= 3'd2) begin
            if (step == 3'd3 && widx == WIDX_W'(PAGE_WORDS - 1)) begin
              next_cnt = CY_LOAD_END;
              next_state = S_LOADEND;
            end else begin
              if (step == 3'd3) begin
                next_widx = widx + WIDX_W'(1);
              end
              next_step = 3'd3;
              next_state = S_SCAN;
            end
          end else if (step < 3'd2 || (op == OP_ERASE && step < 3'd5))
          begin
            next_step = step + 3'd1;
            next_cnt = '0;
            next_state = S_VPP;
          end else begin
            next_cnt = CY_VPH;
            next_state = S_VPPDN;
          end
        end
      end
      S_SCAN: begin
        if (mask[widx]) begin
          next_flash_addr = {addr[ADDR_W-1:WIDX_W], widx};
          next_flash_dq_o = page_buf[widx];
          next_state = S_WSET;
        end else if (widx == WIDX_W'(PAGE_WORDS - 1)) begin
          next_cnt = CY_LOAD_END;
          next_state = S_LOADEND;
        end else begin
          next_widx = widx + WIDX_W'(1);
        end
      end
      S_VPPDN: begin
        if (cnt == '0) begin
          if (op == OP_CLR_STATUS) begin
            next_fstat = FS_RESET;
            next_state = S_IDLE;
          end else begin
            next_flash_addr = addr;
            next_cnt = CY_ACC;
            next_state = S_RLOW;
          end
        end
      end
      S_LOADEND: begin
        if (cnt == '0) begin
          next_mask = '0;
          next_cnt = CY_ACC;
          next_state = S_RLOW;
        end
      end
      S_RLOW: begin
        if (cnt == '0) begin
          if (is_status_op) begin
            next_fstat = {flash_dq_i[7:2], 2'b00};
          end else begin
            next_rdata = flash_dq_i;
          end
          next_cnt = CY_WPH;
          next_state = S_RHIGH;
        end
      end
      S_RHIGH: begin
        if (cnt == '0) begin
          if ((op == OP_PROGRAM || op == OP_ERASE)
              && !fstat[FS_READY]) begin
            next_cnt = CY_ACC;
            next_state = S_RLOW;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    next_flash_ce_n = !(next_state == S_WLOW || next_state == S_RLOW);
    next_flash_oe_n = (next_state != S_RLOW);
    next_flash_dq_oe = (next_state == S_WSET || next_state == S_WLOW
      || next_state == S_WHIGH);
    next_vpp = (next_state == S_VPP || next_state == S_SCAN
      || next_state == S_VPPDN || next_flash_dq_oe);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      op <= OP_READ;
      step <= 3'd0;
      widx <= '0;
      cnt <= '0;
      addr <= '0;
      fstat <= FS_RESET;
      rdata <= '0;
      mask <= '0;
      refused <= 1'b0;
      flash_addr <= '0;
      flash_dq_o <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_word_mode <= 1'b1;
      flash_program_high_level <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      widx <= next_widx;
      cnt <= next_cnt;
      addr <= next_addr;
      fstat <= next_fstat;
      rdata <= next_rdata;
      mask <= next_mask;
      refused <= next_refused;
      flash_addr <= next_flash_addr;
      flash_dq_o <= next_flash_dq_o;
      flash_dq_oe <= next_flash_dq_oe;
      flash_ce_n <= next_flash_ce_n;
      flash_oe_n <= next_flash_oe_n;
      flash_word_mode <= 1'b1;
      flash_program_high_level <= next_vpp;
    end
  end
endmodule
`default_nettype wire

// >>> verification/fps_host_monitor.sv
// assertions on the flash controller's bus and flash pins
`default_nettype none
module fps_host_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // flash pins
  input wire logic [fps_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fps_pkg::DQ_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_word_mode,
  input wire logic flash_program_high_level
);
  import fps_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] lvl_cnt;
  // cycles the program level has been up, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lvl_cnt <= 8'h00;
    else if (!flash_program_high_level) lvl_cnt <= 8'h00;
    else if (lvl_cnt != 8'hFF) lvl_cnt <= lvl_cnt + 8'h01;
  end
  sequence s_wr_fall;
    $fell(flash_ce_n) && flash_oe_n;
  endsequence
  sequence s_wr_low;
    !flash_ce_n && $stable(flash_addr) && $stable(flash_dq_o);
  endsequence
  property p_wr_level;
    s_wr_fall |-> flash_program_high_level && lvl_cnt >= 8'(CY_VPS - 1);
  endproperty
  property p_wr_pulse;
    s_wr_fall |-> s_wr_low [*4] ##1 flash_ce_n;
  endproperty
  property p_wr_hold;
    $rose(flash_ce_n) && $past(flash_oe_n) |->
      flash_dq_oe && $stable(flash_dq_o) && $stable(flash_addr);
  endproperty
  property p_no_fight;
    !flash_oe_n |-> !flash_dq_oe;
  endproperty
  property p_word;
    flash_word_mode;
  endproperty
  property p_poll;
    $fell(flash_oe_n) |-> $fell(flash_ce_n);
  endproperty
  property p_rd_pulse;
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*7] ##1
      (flash_oe_n && flash_ce_n);
  endproperty
  property p_rd_wait;
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wr_level: assert property (p_wr_level)
    else $error("write strobe without settled program level");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe width or address hold wrong");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write data not held at strobe rise");
  a_no_fight: assert property (p_no_fight)
    else $error("data driven while output gate low");
  a_word: assert property (p_word)
    else $error("width pin left word mode");
  a_poll: assert property (p_poll)
    else $error("status read without fresh select");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe length wrong");
  a_rd_wait: assert property (p_rd_wait)
    else $error("read data phase wait state wrong");
endmodule
bind fps_host fps_host_monitor u_fps_host_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_word_mode(flash_word_mode),
  .flash_program_high_level(flash_program_high_level)
);
`default_nettype wire

// >>> verification/fps_flash_model.sv
// behavioural parallel flash answering the controller's pins
`default_nettype none
module fps_flash_model #(
  parameter int BUSY_CY = 200,
  parameter int LOAD_END = 4000
) (
  // pins, sampled on the bench clock
  input wire logic clk,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic program_high_level,
  output logic [15:0] dq_out,
  // fault injection
  input wire logic fail_prog
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [logic [19:0]];
  logic [15:0] pbuf [64];
  logic [63:0] pv;
  logic [13:0] pg;
  logic [19:0] al;
  logic [7:0] sr = 8'h80;
  logic stat = 1'b0, ld = 1'b0, ce_q = 1'b1, rd_q = 1'b0;
  int step = 0, busy = 0, lt = 0;
  initial dq_out = 16'h5A5A;
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    logic u1, u2;
    logic [7:0] c;
    int s;
    u1 = a[14:0] == 15'h5555;
    u2 = a[14:0] == 15'h2AAA;
    c = d[7:0];
    s = step;
    if (ld) begin
      pbuf[a[5:0]] = d;
      pv[a[5:0]] = 1'b1;
      pg = a[19:6];
      lt = 0;
    end else if (busy == 0) begin
      step = 0;
      if ((s == 0 || s == 3) && u1 && c == 8'hAA) step = s + 1;
      if ((s == 1 || s == 4) && u2 && c == 8'h55) step = s + 1;
      if (s == 2 && u1 && c == 8'h80) step = 3;
      if (s == 2 && u1 && c == 8'h70) stat = 1'b1;
      if (s == 2 && u1 && c == 8'h50) sr = 8'h80;
      if (s == 2 && u1 && (c == 8'hF0 || c == 8'h90)) stat = 1'b0;
      if (s == 2 && u1 && c == 8'hA0 && sr[5:4] == 2'b00) begin
        ld = 1'b1;
        pv = '0;
        lt = 0;
        stat = 1'b1;
      end
      if (s == 5 && u1 && c == 8'h10 && sr[5:4] == 2'b00) begin
        mem.delete();
        busy = BUSY_CY;
        sr[7] = 1'b0;
        stat = 1'b1;
      end
    end
  endtask
  always @(posedge clk) begin
    if (ld) lt++;
    if (ld && lt >= LOAD_END) begin
      ld = 1'b0;
      for (int i = 0; i < 64; i++)
        if (pv[i]) mem[{pg, 6'(i)}] = pbuf[i];
      busy = BUSY_CY;
      sr[7] = 1'b0;
    end
    if (busy == 1) sr = sr | (fail_prog ? 8'h90 : 8'h80);
    if (busy > 0) busy--;
    // read data frozen at the later of select and gate falling
    if (!ce_n && !oe_n && !rd_q)
      dq_out <= stat ? {8'h00, sr & 8'hFC} : (mem.exists(addr) ? mem[addr]
        : 16'hFFFF);
    else if (ce_n || oe_n) dq_out <= ~dq_out;
    if (ce_q && !ce_n) al = addr;
    if (!ce_q && ce_n && oe_n && program_high_level) wr(al, dq_in);
    ce_q = ce_n;
    rd_q = !ce_n && !oe_n;
  end
endmodule
`default_nettype wire

// >>> verification/test_fps_host.sv
// self-checking regression of the flash controller over its bus
`default_nettype none
module test_fps_host;
  timeunit 1ns;
  timeprecision 100ps;
  import fps_pkg::*;
  logic hclk, hresetn, hwrite, hreadyout, hresp, fail_prog, clk_en;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, st, dum;
  logic [19:0] f_addr;
  logic [15:0] f_do, f_di;
  logic f_oe, f_ce_n, f_oe_n, f_wm, f_lvl;
  int fails = 0;
  int n_checks = 0;
  fps_host u_fps_host (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .flash_addr(f_addr),
    .flash_dq_o(f_do), .flash_dq_oe(f_oe), .flash_dq_i(f_di),
    .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n), .flash_word_mode(f_wm),
    .flash_program_high_level(f_lvl)
  );
  fps_flash_model u_fps_flash_model (
    .clk(hclk), .addr(f_addr), .dq_in(f_do), .ce_n(f_ce_n),
    .oe_n(f_oe_n), .program_high_level(f_lvl), .dq_out(f_di), .fail_prog(fail_prog)
  );
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fails++;
        close_out;
      end else @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  // issue an operation and poll until the controller is idle again
  task automatic op(input logic [2:0] c);
    int k;
    k = 0;
    bus(1'b1, REG_CMD, {29'h0, c}, dum);
    bus(1'b0, REG_STATUS, 32'h0, st);
    while (st[ST_BUSY] !== 1'b0) begin
      k++;
      if (k > 3000) begin
        fails++;
        close_out;
      end else bus(1'b0, REG_STATUS, 32'h0, st);
    end
  endtask
  task automatic ld(input logic [19:0] a, input logic [15:0] d);
    bus(1'b1, REG_ADDR, {12'h0, a}, dum);
    bus(1'b1, REG_DATA, {16'h0, d}, dum);
  endtask
  task automatic arr(input string nm, input logic [19:0] a,
    input logic [2:0] c, input logic [15:0] e);
    bus(1'b1, REG_ADDR, {12'h0, a}, dum);
    op(c);
    bus(1'b0, REG_RDATA, 32'h0, st);
    chk(nm, st, {16'h0, e});
  endtask
  task automatic stat(input string nm, input logic [7:0] e);
    bus(1'b0, REG_STATUS, 32'h0, st);
    chk(nm, {24'h0, st[15:8]}, {24'h0, e});
  endtask
  initial begin
    hresetn = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fail_prog = 1'b0;
    clk_en = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0, st);
    chk("reset status", st, 32'h0000_8000);
    chk("hresp okay", {31'h0, hresp}, 32'h0);
    bus(1'b0, 8'h20, 32'h0, st);
    chk("unmapped", st, 32'h0);
    ld(20'hABC85, 16'h1234);
    ld(20'hABC82, 16'hABCD);
    ld(20'hABCBF, 16'h0F0F);
    op(OP_PROGRAM);
    stat("program done", 8'h80);
    arr("status mode", 20'hABC82, OP_READ, 16'h0080);
    arr("word 2", 20'hABC82, OP_RD_ARRAY, 16'hABCD);
    arr("word 5", 20'hABC85, OP_READ, 16'h1234);
    arr("word 63", 20'hABCBF, OP_READ, 16'h0F0F);
    arr("unloaded", 20'hABC86, OP_READ, 16'hFFFF);
    op(OP_RD_STATUS);
    stat("status cmd", 8'h80);
    arr("status held", 20'hABC85, OP_READ, 16'h0080);
    op(OP_ERASE);
    arr("erased", 20'hABC82, OP_RD_ARRAY, 16'hFFFF);
    fail_prog <= 1'b1;
    ld(20'h00040, 16'h5555);
    op(OP_PROGRAM);
    stat("program fail", 8'h90);
    fail_prog <= 1'b0;
    op(OP_PROGRAM);
    bus(1'b0, REG_STATUS, 32'h0, st);
    chk("refused", {31'h0, st[ST_REFUSED]}, 32'h1);
    stat("fail kept", 8'h90);
    op(OP_CLR_STATUS);
    stat("cleared", 8'h80);
    ld(20'h00041, 16'h2222);
    op(OP_PROGRAM);
    arr("after clear", 20'h00041, OP_RD_ARRAY, 16'h2222);
    // a write while the enable is low must leave the address untouched
    clk_en <= 1'b0;
    bus(1'b1, REG_ADDR, 32'h0000_0123, dum);
    clk_en <= 1'b1;
    bus(1'b0, REG_ADDR, 32'h0, st);
    chk("frozen addr", st, 32'h0000_0041);
    close_out;
  end
endmodule
`default_nettype wire
